// ### dtps_pkg.sv
// constants and types shared by the dram thermal and power services
package dtps_pkg;
	localparam int N_CH = 4;
	localparam int N_DIMM = 3;
	localparam int N_RANK = 4;
	localparam int TEMP_W = 8;
	localparam int EINC_W = 16;
	// service indexes of the package configuration commands
	localparam logic [7:0] IDX_ENERGY = 8'h04;
	localparam logic [7:0] IDX_AMBIENT = 8'h13;
	localparam logic [7:0] IDX_CH_TEMP = 8'h16;
	localparam logic [7:0] IDX_PLIMIT = 8'h22;
	localparam logic [7:0] IDX_PINFO_LO = 8'h23;
	localparam logic [7:0] IDX_PINFO_HI = 8'h24;
	localparam logic [7:0] IDX_THROTTLE = 8'h26;
	localparam logic [15:0] PARAM_ALL_CH = 16'h00FF;
	localparam logic [15:0] PARAM_LAST_CH = 16'h0003;
	// power limit word layout
	localparam int PL_EN_BIT = 15;
	localparam logic [31:0] PL_LIMIT_MASK = 32'h00007FFF;
	localparam logic [31:0] PL_WIN_MASK = 32'h00FE0000;
	localparam logic [31:0] PL_WR_MASK = 32'h00FEFFFF;
	localparam int INB_LOCK_BIT = 31;
	localparam logic [31:0] ZERO32 = 32'h00000000;
	localparam logic [TEMP_W-1:0] TEMP_ZERO = 8'h00;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] index;
		logic [15:0] param;
		logic [31:0] wdata;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [31:0] data;
	} rsp_t;
endpackage

// ### wrap_accum.sv
// wrapping accumulator for energy and throttle time
`timescale 1ns/1ps
module wrap_accum #(
	parameter int W = 32,
	parameter int IW = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [IW-1:0] i_inc,
	output logic [W-1:0] o_count
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	// sum keeps only W bits so overflow wraps around modulo 2**W
	assign count_nxt = count_r + W'(i_inc);
	assign o_count = count_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule

// ### dram_thermal_power_services.sv
// dram thermal and power services behind the sideband thermal link
// Operation
// [RL1] ambient reference is written by the host and read back as stored
// [RL2] one ambient value serves every channel and dimm, no location offset
// [RL3] channel temperature is the maximum over all dimms and ranks
// [RL4] empty channel reads ambient when estimating, zero with sensors
// [RL5] energy read parameter picks a channel; 0x00FF returns all channels
// [RL6] energy is a 32-bit wrapping counter returned on each read
// [RL7] host reads energy at least every 16 s, ideally every 100 ms
// [RL8] host subtracts successive energy readings in two's complement
// [RL9] 64-bit power info is read as two separate 32-bit halves
// [RL10] power info loads at boot completion regardless of limit enable
// [RL11] limit in bits 14:0, enable bit 15; limiting acts only when enabled
// [RL12] limiting is disabled after reset; limit values have no default
// [RL13] one write may set enable and limit values together
// [RL14] host supplies every field correctly on each limit write
// [RL15] time window bits 23:17, x in 23:22 and y in 21:17
// [RL16] host programs a window between 250 ms and 40 s
// [RL17] in-band limit bit 31 set locks out later in-band accesses
// [RL18] throttle status is a 32-bit wrapping sum of dimm low power time
// [RL19] returned energy, power and time use package unit encoding
// [RL20] channel index 000 to 011 selects physical channels 0 to 3
// [RL21] reserved limit word bits ignore writes and read back zero
`timescale 1ns/1ps
module dram_thermal_power_services
	import dtps_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire cmd_t I_CMD,
	output rsp_t O_RSP,
	input wire logic [N_CH-1:0][N_DIMM-1:0][N_RANK-1:0][TEMP_W-1:0] I_RANK_TEMP,
	input wire logic [N_CH-1:0] I_CH_POPULATED,
	input wire logic I_ESTIMATION_MODE,
	input wire logic [N_CH-1:0][EINC_W-1:0] I_ENERGY_INC,
	input wire logic [N_CH*N_DIMM-1:0] I_DIMM_LOW_POWER,
	input wire logic I_MEM_STALL,
	input wire logic I_TIME_TICK,
	input wire logic I_BOOT_DONE_FLAG,
	input wire logic [63:0] I_POWER_INFO,
	input wire logic I_INBAND_WR,
	input wire logic [31:0] I_INBAND_WDATA,
	output logic [TEMP_W-1:0] O_AMBIENT,
	output logic O_LIMIT_ACTIVE,
	output logic [14:0] O_POWER_LIMIT,
	output logic [6:0] O_TIME_WINDOW,
	output logic O_INBAND_LOCKED
);
	localparam int CNT_W = 32;
	localparam int TOT_W = EINC_W + 2;
	localparam int THR_W = $clog2(N_CH*N_DIMM+1);

	logic [TEMP_W-1:0] amb_r;
	logic [31:0] limit_r;
	logic [31:0] inband_r;
	logic [63:0] pinfo_r;
	logic boot_seen_r;
	rsp_t rsp_r;
	rsp_t rsp_nxt;
	logic [N_CH-1:0][CNT_W-1:0] energy_ch;
	logic [CNT_W-1:0] energy_all;
	logic [CNT_W-1:0] throttle_cnt;
	logic [TOT_W-1:0] energy_sum;
	logic [THR_W-1:0] thr_inc;
	logic [N_CH-1:0][TEMP_W-1:0] ch_temp;
	logic wr_limit;
	logic is_read;

	assign is_read = I_CMD.valid && !I_CMD.write;
	assign wr_limit = I_CMD.valid && I_CMD.write && I_CMD.index == IDX_PLIMIT;

	// =====================================================================
	// channel temperature
	// =====================================================================
	genvar gc;
	generate
		for (gc = 0; gc < N_CH; gc++) begin : g_ch
			always_comb begin
				logic [TEMP_W-1:0] mx;
				mx = TEMP_ZERO;
				for (int d = 0; d < N_DIMM; d++) begin
					for (int r = 0; r < N_RANK; r++) begin
						if (I_RANK_TEMP[gc][d][r] > mx) begin
							mx = I_RANK_TEMP[gc][d][r]; // RL3
						end
					end
				end
				// override last so an empty slot ignores stale rank values
				if (!I_CH_POPULATED[gc]) begin
					// RL2 RL4
					mx = I_ESTIMATION_MODE ? amb_r : TEMP_ZERO;
				end
				ch_temp[gc] = mx;
			end

			// per channel energy counters
			wrap_accum #(.W(CNT_W), .IW(EINC_W)) u_energy (
				.i_clk(I_CLK_SYS),
				.i_rst(I_RESET),
				.i_inc(I_ENERGY_INC[gc]),
				.o_count(energy_ch[gc])
			); // RL6
		end
	endgenerate

	// =====================================================================
	// energy and throttle accumulation
	// =====================================================================
	always_comb begin
		energy_sum = '0;
		for (int c = 0; c < N_CH; c++) begin
			energy_sum = energy_sum + TOT_W'(I_ENERGY_INC[c]);
		end
	end

	// a separate total keeps the all-channel sum consistent across wraps
	wrap_accum #(.W(CNT_W), .IW(TOT_W)) u_energy_all (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RESET),
		.i_inc(energy_sum),
		.o_count(energy_all)
	); // RL5 RL6

	always_comb begin
		thr_inc = '0;
		// stalls are not low power time, so they are not counted
		if (I_TIME_TICK && !I_MEM_STALL) begin
			for (int k = 0; k < N_CH*N_DIMM; k++) begin
				thr_inc = thr_inc + THR_W'(I_DIMM_LOW_POWER[k]); // RL18
			end
		end
	end

	wrap_accum #(.W(CNT_W), .IW(THR_W)) u_throttle (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RESET),
		.i_inc(thr_inc),
		.o_count(throttle_cnt)
	); // RL18

	// =====================================================================
	// writable state
	// =====================================================================
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			amb_r <= TEMP_ZERO;
		end else if (I_CMD.valid && I_CMD.write && I_CMD.index == IDX_AMBIENT) begin
			amb_r <= I_CMD.wdata[TEMP_W-1:0]; // RL1
		end
	end

	// limit values cleared only for a clean start; software must load them
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			limit_r <= ZERO32; // RL12
		end else if (wr_limit) begin
			limit_r <= I_CMD.wdata & PL_WR_MASK; // RL13 RL21
		end
	end

	// lock bit is sticky: once set, later in-band writes are dropped
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			inband_r <= ZERO32;
		end else if (I_INBAND_WR && !inband_r[INB_LOCK_BIT]) begin
			inband_r <= I_INBAND_WDATA; // RL17
		end
	end

	// power info captured on the rising boot completion flag
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			boot_seen_r <= 1'b0;
			pinfo_r <= '0;
		end else begin
			boot_seen_r <= I_BOOT_DONE_FLAG;
			if (I_BOOT_DONE_FLAG && !boot_seen_r) begin
				pinfo_r <= I_POWER_INFO; // RL10
			end
		end
	end

	// =====================================================================
	// command response
	// =====================================================================
	always_comb begin
		rsp_nxt.valid = I_CMD.valid;
		rsp_nxt.err = 1'b0;
		rsp_nxt.data = ZERO32;
		if (I_CMD.valid && I_CMD.write) begin
			rsp_nxt.err = !(I_CMD.index == IDX_AMBIENT || wr_limit);
		end else if (is_read) begin
			unique case (I_CMD.index)
				IDX_AMBIENT: rsp_nxt.data = 32'(amb_r); // RL1
				IDX_CH_TEMP: rsp_nxt.data = 32'(ch_temp); // RL3
				IDX_ENERGY: begin
					if (I_CMD.param == PARAM_ALL_CH) begin
						rsp_nxt.data = energy_all; // RL5
					end else if (I_CMD.param <= PARAM_LAST_CH) begin
						rsp_nxt.data = energy_ch[I_CMD.param[1:0]]; // RL20
					end else begin
						rsp_nxt.err = 1'b1;
					end
				end
				IDX_PINFO_LO: rsp_nxt.data = pinfo_r[31:0]; // RL9
				IDX_PINFO_HI: rsp_nxt.data = pinfo_r[63:32]; // RL9
				IDX_PLIMIT: rsp_nxt.data = limit_r; // RL21
				IDX_THROTTLE: rsp_nxt.data = throttle_cnt; // RL18
				default: rsp_nxt.err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt; // RL19
		end
	end

	// =====================================================================
	// outputs
	// =====================================================================
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			O_LIMIT_ACTIVE <= 1'b0;
			O_POWER_LIMIT <= '0;
			O_TIME_WINDOW <= '0;
			O_AMBIENT <= TEMP_ZERO;
			O_INBAND_LOCKED <= 1'b0;
		end else begin
			O_LIMIT_ACTIVE <= limit_r[PL_EN_BIT]; // RL11
			O_POWER_LIMIT <= limit_r[14:0]; // RL11
			O_TIME_WINDOW <= limit_r[23:17]; // RL15
			O_AMBIENT <= amb_r; // RL2
			O_INBAND_LOCKED <= inband_r[INB_LOCK_BIT]; // RL17
		end
	end

	assign O_RSP = rsp_r;

	// =====================================================================
	// assertions
	// =====================================================================
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);

	a_ambient_readback: assert property ( // RL1
		I_CMD.valid && I_CMD.write && I_CMD.index == IDX_AMBIENT ##1
		is_read && I_CMD.index == IDX_AMBIENT
		|=> O_RSP.data == 32'($past(I_CMD.wdata[TEMP_W-1:0], 2)))
		else $error("ambient read-back differs from write");
	a_empty_channel: assert property ( // RL4
		is_read && I_CMD.index == IDX_CH_TEMP && !I_CH_POPULATED[N_CH-1]
		|=> O_RSP.data[N_CH*TEMP_W-1 -: TEMP_W] ==
		($past(I_ESTIMATION_MODE) ? $past(amb_r) : TEMP_ZERO))
		else $error("empty channel temperature wrong");
	a_energy_all: assert property ( // RL5
		is_read && I_CMD.index == IDX_ENERGY && I_CMD.param == PARAM_ALL_CH
		|=> O_RSP.valid && !O_RSP.err && O_RSP.data == $past(energy_all))
		else $error("all-channel energy read wrong");
	a_energy_wrap: assert property ( // RL6
		!$past(I_RESET) |->
		energy_all == $past(energy_all) + 32'($past(energy_sum)))
		else $error("energy total not wrapping sum");
	a_info_halves: assert property ( // RL9
		is_read && I_CMD.index == IDX_PINFO_HI
		|=> O_RSP.data == $past(pinfo_r[63:32]))
		else $error("power info high half wrong");
	a_info_load: assert property ( // RL10
		I_BOOT_DONE_FLAG && !boot_seen_r
		|=> pinfo_r == $past(I_POWER_INFO))
		else $error("power info not loaded at boot");
	a_limit_enable: assert property ( // RL11
		wr_limit |=> ##1 O_LIMIT_ACTIVE == $past(I_CMD.wdata[PL_EN_BIT], 2)
		&& O_POWER_LIMIT == $past(I_CMD.wdata[14:0], 2))
		else $error("limit enable or value not applied");
	a_limit_reserved: assert property ( // RL21
		wr_limit |=> (limit_r & ~PL_WR_MASK) == ZERO32
		&& O_RSP.valid && !O_RSP.err)
		else $error("reserved limit bits stored");
	a_inband_lock: assert property ( // RL17
		inband_r[INB_LOCK_BIT] && I_INBAND_WR |=> $stable(inband_r))
		else $error("in-band write passed the lock");
	a_throttle_stall: assert property ( // RL18
		I_MEM_STALL |=> throttle_cnt == $past(throttle_cnt))
		else $error("throttle time counted during stall");
	a_rsp_timing: assert property (
		I_CMD.valid |=> O_RSP.valid ##1 !O_RSP.valid || $past(I_CMD.valid))
		else $error("response not a single-cycle pulse");
	a_limit_reset: assert property ( // RL12
		$past(I_RESET) |-> !O_LIMIT_ACTIVE)
		else $error("limiting active right after reset");
	a_throttle_count: assert property ( // RL18
		I_TIME_TICK && !I_MEM_STALL |=> throttle_cnt ==
		$past(throttle_cnt) + 32'($countones($past(I_DIMM_LOW_POWER))))
		else $error("throttle time not the low power dimm count");
	a_energy_channel: assert property ( // RL20
		is_read && I_CMD.index == IDX_ENERGY && I_CMD.param <= PARAM_LAST_CH
		|=> !O_RSP.err && O_RSP.data == $past(energy_ch[I_CMD.param[1:0]]))
		else $error("single channel energy read wrong");
	a_channel_max: assert property ( // RL3
		is_read && I_CMD.index == IDX_CH_TEMP && I_CH_POPULATED[0]
		|=> O_RSP.data[TEMP_W-1:0] >= $past(I_RANK_TEMP[0][N_DIMM-1][N_RANK-1]))
		else $error("channel temperature below a rank temperature");

	c_limit_enable: cover property (wr_limit && I_CMD.wdata[PL_EN_BIT]);
	c_energy_channel: cover property (is_read && I_CMD.index == IDX_ENERGY
		&& I_CMD.param == 16'h0002);
	c_energy_wraps: cover property (energy_all < $past(energy_all));
	c_boot_load: cover property (I_BOOT_DONE_FLAG && !boot_seen_r);
	c_write_then_read: cover property (I_CMD.valid && I_CMD.write
		##1 is_read);
endmodule

// ### host_model.sv
// sideband host model issuing package configuration commands
`timescale 1ns/1ps
module host_model
	import dtps_pkg::*;
(
	input wire logic i_clk,
	input wire rsp_t i_rsp,
	output cmd_t o_cmd
);
	// ========================================
	// one request a call, answer taken next cycle
	task automatic xfer(input logic wr, input logic [7:0] ix,
		input logic [15:0] pm, input logic [31:0] wd, output rsp_t r);
		@(negedge i_clk);
		// whole word on every write, never a partial field
		o_cmd = '{1'b1, wr, ix, pm, wd};
		@(negedge i_clk);
		r = i_rsp;
		// idle param and wdata scrambled so a stale value cannot pass
		o_cmd = '{1'b0, o_cmd.write, o_cmd.index, ~o_cmd.param,
			~o_cmd.wdata};
	endtask

	// write, then a read of the same service on the very next cycle
	task automatic wr_rd(input logic [7:0] ix, input logic [31:0] wd,
		output rsp_t r);
		@(negedge i_clk);
		o_cmd = '{1'b1, 1'b1, ix, 16'h0000, wd};
		@(negedge i_clk);
		o_cmd = '{1'b1, 1'b0, ix, 16'h0000, ~wd};
		@(negedge i_clk);
		r = i_rsp;
		o_cmd = '{1'b0, 1'b0, ix, 16'hFFFF, wd};
	endtask

	initial o_cmd = '0;
endmodule

// ### dram_thermal_power_services_tb.sv
// self-checking bench for the dram thermal and power services
`timescale 1ns/1ps
module dram_thermal_power_services_tb
	import dtps_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	cmd_t cmd;
	rsp_t rsp, r;
	logic [N_CH-1:0][N_DIMM-1:0][N_RANK-1:0][TEMP_W-1:0] rt;
	logic [N_CH-1:0] pop = 4'h7;
	logic est = 1'b1;
	logic [N_CH-1:0][EINC_W-1:0] einc;
	logic [11:0] lp = 12'h007;
	logic stall = 1'b0, tick = 1'b0, boot = 1'b0, ibw = 1'b0;
	logic [63:0] pinfo = 64'h0123456789ABCDEF;
	logic [31:0] ibd = 32'h00000000, a;
	logic [7:0] amb;
	logic act, lock;
	logic [14:0] plim;
	logic [6:0] win;
	int errors = 0, compares = 0;

	always #2 clk = ~clk;

	host_model i_host (.i_clk(clk), .i_rsp(rsp), .o_cmd(cmd));

	dram_thermal_power_services i_dut (.I_CLK_SYS(clk), .I_RESET(rst),
		.I_CMD(cmd), .O_RSP(rsp), .I_RANK_TEMP(rt), .I_CH_POPULATED(pop),
		.I_ESTIMATION_MODE(est), .I_ENERGY_INC(einc),
		.I_DIMM_LOW_POWER(lp), .I_MEM_STALL(stall), .I_TIME_TICK(tick),
		.I_BOOT_DONE_FLAG(boot), .I_POWER_INFO(pinfo), .I_INBAND_WR(ibw),
		.I_INBAND_WDATA(ibd), .O_AMBIENT(amb), .O_LIMIT_ACTIVE(act),
		.O_POWER_LIMIT(plim), .O_TIME_WINDOW(win), .O_INBAND_LOCKED(lock));

	// ========================================
	// shared helpers
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic rq(input logic wr, input logic [7:0] ix,
		input logic [15:0] pm, input logic [31:0] wd);
		i_host.xfer(wr, ix, pm, wd, r);
	endtask

	task automatic end_sim;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ========================================
	// scenarios
	task automatic t_reset;
		rq(1'b0, IDX_PLIMIT, 16'h0000, ZERO32);
		chk("limit word", r.data, ZERO32);
		chk("limit active", {31'h0, act}, ZERO32);
		rq(1'b0, IDX_PINFO_LO, 16'h0000, ZERO32);
		chk("info before boot", r.data, ZERO32);
		$display("reset test done");
	endtask

	task automatic t_regs;
		// read right behind the write must already see the new value
		i_host.wr_rd(IDX_AMBIENT, 32'h0000002D, r);
		chk("ambient read", r.data, 32'h0000002D);
		chk("ambient out", {24'h0, amb}, 32'h0000002D);
		// reserved bits set on purpose, enable and fields in one write
		rq(1'b1, IDX_PLIMIT, 16'h0000, 32'hFF158064);
		rq(1'b0, IDX_PLIMIT, 16'h0000, ZERO32);
		chk("limit masked", r.data, 32'h00148064);
		chk("limit outs", {act, plim, win}, {1'b1, 15'h0064, 7'h0A});
		rq(1'b1, IDX_PLIMIT, 16'h0000, 32'h00140064);
		rq(1'b0, IDX_PLIMIT, 16'h0000, ZERO32);
		chk("limit off", {r.data[31:1], act}, 32'h00140064);
		rq(1'b1, IDX_CH_TEMP, 16'h0000, 32'h12345678);
		chk("bad write", {r.err, r.valid}, 32'h00000003);
		rq(1'b0, 8'h99, 16'h0000, ZERO32);
		chk("bad read", {r.data[30:0], r.err}, 32'h00000001);
		$display("register test done");
	endtask

	task automatic t_temp;
		rq(1'b0, IDX_CH_TEMP, 16'h0000, ZERO32);
		chk("temp est", r.data, 32'h2D3B2B1B);
		est = 1'b0;
		rq(1'b0, IDX_CH_TEMP, 16'h0000, ZERO32);
		chk("temp sensor", r.data, 32'h003B2B1B);
		$display("temperature test done");
	endtask

	task automatic t_energy;
		logic [31:0] inc;
		for (int i = 0; i < 5; i++) begin
			inc = (i == 4) ? 32'h00000AAA : 32'(einc[i]);
			// polled within a few cycles, far inside the limit
			rq(1'b0, IDX_ENERGY, (i == 4) ? PARAM_ALL_CH : 16'(i), ZERO32);
			a = r.data;
			repeat (3) @(negedge clk);
			rq(1'b0, IDX_ENERGY, (i == 4) ? PARAM_ALL_CH : 16'(i), ZERO32);
			chk("energy delta", r.data - a, inc * 5);
		end
		rq(1'b0, IDX_ENERGY, 16'h0004, ZERO32);
		chk("energy bad ch", {31'h0, r.err}, 32'h00000001);
		$display("energy test done");
	endtask

	task automatic t_info;
		boot = 1'b1;
		repeat (2) @(negedge clk);
		pinfo = ~pinfo;
		rq(1'b0, IDX_PINFO_LO, 16'h0000, ZERO32);
		chk("info low", r.data, 32'h89ABCDEF);
		rq(1'b0, IDX_PINFO_HI, 16'h0000, ZERO32);
		chk("info high", r.data, 32'h01234567);
		$display("power info test done");
	endtask

	task automatic t_throttle;
		rq(1'b0, IDX_THROTTLE, 16'h0000, ZERO32);
		a = r.data;
		tick = 1'b1;
		repeat (5) @(negedge clk);
		// stalled ticks must not count
		stall = 1'b1;
		repeat (4) @(negedge clk);
		tick = 1'b0;
		stall = 1'b0;
		rq(1'b0, IDX_THROTTLE, 16'h0000, ZERO32);
		chk("throttle delta", r.data - a, 32'h0000000F);
		$display("throttle test done");
	endtask

	task automatic t_lock;
		@(negedge clk);
		ibw = 1'b1;
		ibd = 32'h80000000;
		@(negedge clk);
		ibw = 1'b0;
		repeat (2) @(negedge clk);
		chk("locked", {31'h0, lock}, 32'h00000001);
		rq(1'b1, IDX_PLIMIT, 16'h0000, 32'h00148064);
		@(negedge clk);
		ibw = 1'b1;
		ibd = 32'h00008123;
		@(negedge clk);
		ibw = 1'b0;
		repeat (2) @(negedge clk);
		// bit 31 clear here, so a passed write would drop the lock
		chk("lock held", {31'h0, lock}, 32'h00000001);
		rq(1'b0, IDX_PLIMIT, 16'h0000, ZERO32);
		chk("inband ignored", r.data, 32'h00148064);
		$display("lock test done");
	endtask

	initial begin
		for (int c = 0; c < N_CH; c++) begin
			einc[c] = 16'(c + 1) * 16'h0111;
			for (int d = 0; d < N_DIMM; d++) begin
				for (int k = 0; k < N_RANK; k++) begin
					rt[c][d][k] = 8'h10 + 8'(c * 16 + d * 4 + k);
				end
			end
		end
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_reset();
		t_regs();
		t_temp();
		t_energy();
		t_info();
		t_throttle();
		t_lock();
		end_sim();
	end

	// whole run is about a hundred cycles
	initial begin
		#20000;
		errors++;
		end_sim();
	end
endmodule
